// *** rtl/rsecr_regs.sv ***
// Interrupt summary, identity, filter/range control and threshold config registers
`default_nettype none
module rsecr_regs
    import rsecr_pkg::*;
#(
    parameter logic [7:0] IDENTITY_CODE = 8'h5A  // Arbitrary value
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          soft_reset,
    input  wire rsecr_access_t acc,
    output logic [7:0]         rdata,
    input  wire logic          boot_done,
    input  wire rsecr_events_t ev,
    input  wire logic          fifo_interrupt_enable,
    input  wire logic          threshold_interrupt_enable,
    input  wire logic          data_ready_interrupt_enable,
    input  wire logic [2:0]    msb_read,
    input  wire rsecr_mode_t   mode,
    input  wire logic [2:0]    output_sample_rate,
    input  wire logic          zero_rate_assert,
    input  wire logic          range_doubling,
    output rsecr_ctrl_t        ctrl,
    output logic [2:0]         full_scale_code,
    output logic               event_latch_enable,
    output logic [2:0]         axis_event_enable,
    output logic               highpass_reinit,
    output logic               threshold_reset
);
    // Local sizes and field positions
    localparam int BYTE_WIDTH  = 8;
    localparam int PAIR_WIDTH  = 2;
    localparam int AXIS_COUNT  = 3;
    localparam int RATE_WIDTH  = 3;
    localparam int AXIS_X      = 0;
    localparam int AXIS_Y      = 1;
    localparam int AXIS_Z      = 2;
    localparam int CFG_AXIS_HI = AXIS_COUNT - 1;
    localparam int PAD_WIDTH   = BYTE_WIDTH - RSECR_CFG_WIDTH;
    localparam logic [AXIS_COUNT-1:0] ALL_AXES     = 3'h7;
    localparam logic [RATE_WIDTH-1:0] RATE_RESET   = 3'h0;
    localparam logic [PAD_WIDTH-1:0]  CFG_PAD      = 4'h0;
    localparam logic                  FLAG_CLEAR   = 1'b0;
    localparam logic                  FLAG_SET     = 1'b1;
    localparam rsecr_ctrl_t           CTRL_DEFAULT = rsecr_ctrl_t'(RSECR_RESET_CONTROL);

    // Stored control fields
    logic [PAIR_WIDTH-1:0]      lowpass_ff;
    logic                       three_wire_ff;
    logic [PAIR_WIDTH-1:0]      highpass_cutoff_ff;
    logic                       highpass_enable_ff;
    logic [PAIR_WIDTH-1:0]      full_scale_ff;

    // Stored threshold config, status and history
    logic                       latch_enable_ff;
    logic [AXIS_COUNT-1:0]      axis_enable_ff;
    logic                       boot_ff;
    logic                       drdy_ff;
    logic                       msb_x_seen_ff;
    logic                       msb_y_seen_ff;
    logic                       msb_z_seen_ff;
    rsecr_mode_t                mode_ff;
    logic [RATE_WIDTH-1:0]      rate_ff;

    // Combinational helpers
    rsecr_ctrl_t                wctrl;
    rsecr_ctrl_t                control_fields;
    logic [BYTE_WIDTH-1:0]      control_byte;
    logic [BYTE_WIDTH-1:0]      rtcfg_byte;
    logic [BYTE_WIDTH-1:0]      summary_byte;
    logic                       control_write;
    logic                       rtcfg_write;
    logic                       fifo_event;
    logic                       event_active_flag;
    logic [AXIS_COUNT-1:0]      enabled_axis_events;
    logic                       fifo_summary;
    logic                       threshold_summary;
    logic [AXIS_COUNT-1:0]      msb_seen;
    logic [AXIS_COUNT-1:0]      nxt_msb_seen;
    logic                       ready_request;
    logic                       ready_arm;
    logic                       ready_done;
    logic                       mode_changed;
    logic                       rate_changed;
    logic                       from_standby;
    logic                       from_ready;

    // Write strobe for one register offset
    function automatic logic hit(input rsecr_access_t a, input logic [7:0] off);
        hit = a.wr && (a.addr == off);
    endfunction

    // Event flag qualified by its enable
    function automatic logic gated(input logic flag, input logic enable);
        gated = flag && enable;
    endfunction

    // Write strobes and write data viewed as fields
    assign control_write = hit(acc, RSECR_ADDR_CONTROL);
    assign rtcfg_write   = hit(acc, RSECR_ADDR_RTCFG);
    assign wctrl         = rsecr_ctrl_t'(acc.wdata);

    // Low-pass cutoff select
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lowpass_ff <= CTRL_DEFAULT.lowpass_cutoff_select;
        end else if (soft_reset) begin
            lowpass_ff <= CTRL_DEFAULT.lowpass_cutoff_select;
        end else if (control_write) begin
            lowpass_ff <= wctrl.lowpass_cutoff_select;
        end
    end

    // Three-wire serial select, four-wire by default
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            three_wire_ff <= CTRL_DEFAULT.three_wire_select;
        end else if (soft_reset) begin
            three_wire_ff <= CTRL_DEFAULT.three_wire_select;
        end else if (control_write) begin
            three_wire_ff <= wctrl.three_wire_select;
        end
    end

    // High-pass cutoff select
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            highpass_cutoff_ff <= CTRL_DEFAULT.highpass_cutoff_select;
        end else if (soft_reset) begin
            highpass_cutoff_ff <= CTRL_DEFAULT.highpass_cutoff_select;
        end else if (control_write) begin
            highpass_cutoff_ff <= wctrl.highpass_cutoff_select;
        end
    end

    // High-pass enable, off by default
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            highpass_enable_ff <= CTRL_DEFAULT.highpass_enable;
        end else if (soft_reset) begin
            highpass_enable_ff <= CTRL_DEFAULT.highpass_enable;
        end else if (control_write) begin
            highpass_enable_ff <= wctrl.highpass_enable;
        end
    end

    // Full-scale range select
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            full_scale_ff <= CTRL_DEFAULT.full_scale_select;
        end else if (soft_reset) begin
            full_scale_ff <= CTRL_DEFAULT.full_scale_select;
        end else if (control_write) begin
            full_scale_ff <= wctrl.full_scale_select;
        end
    end

    // Event latch enable; upper write bits dropped
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            latch_enable_ff <= RSECR_RESET_RTCFG[RSECR_CFG_ELE];
        end else if (soft_reset) begin
            latch_enable_ff <= RSECR_RESET_RTCFG[RSECR_CFG_ELE];
        end else if (rtcfg_write) begin
            latch_enable_ff <= acc.wdata[RSECR_CFG_ELE];
        end
    end

    // Per-axis event detection enables
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            axis_enable_ff <= RSECR_RESET_RTCFG[CFG_AXIS_HI:0];
        end else if (soft_reset) begin
            axis_enable_ff <= RSECR_RESET_RTCFG[CFG_AXIS_HI:0];
        end else if (rtcfg_write) begin
            axis_enable_ff <= acc.wdata[CFG_AXIS_HI:0];
        end
    end

    // Boot flag: sticky until any reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            boot_ff <= FLAG_CLEAR;
        end else if (soft_reset) begin
            boot_ff <= FLAG_CLEAR;
        end else if (boot_done) begin
            boot_ff <= FLAG_SET;
        end
    end

    // Data-ready set and clear conditions
    assign ready_request = gated(ev.sample_ready_any, data_ready_interrupt_enable);
    assign ready_arm     = ready_request && !drdy_ff;
    assign ready_done    = drdy_ff && (nxt_msb_seen == ALL_AXES);

    // Data-ready summary; a fresh ready at the clear keeps it set
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            drdy_ff <= FLAG_CLEAR;
        end else if (soft_reset) begin
            drdy_ff <= FLAG_CLEAR;
        end else if (ready_arm) begin
            drdy_ff <= FLAG_SET;
        end else if (ready_done) begin
            drdy_ff <= ready_request;
        end
    end

    // MSB reads gathered so far
    assign msb_seen = {msb_z_seen_ff, msb_y_seen_ff, msb_x_seen_ff};
    always_comb begin
        nxt_msb_seen = msb_seen | msb_read;
    end

    // X axis MSB seen while data is ready
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            msb_x_seen_ff <= FLAG_CLEAR;
        end else if (soft_reset) begin
            msb_x_seen_ff <= FLAG_CLEAR;
        end else if (ready_arm) begin
            msb_x_seen_ff <= msb_read[AXIS_X];
        end else if (ready_done) begin
            msb_x_seen_ff <= FLAG_CLEAR;
        end else if (drdy_ff) begin
            msb_x_seen_ff <= nxt_msb_seen[AXIS_X];
        end
    end

    // Y axis MSB seen while data is ready
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            msb_y_seen_ff <= FLAG_CLEAR;
        end else if (soft_reset) begin
            msb_y_seen_ff <= FLAG_CLEAR;
        end else if (ready_arm) begin
            msb_y_seen_ff <= msb_read[AXIS_Y];
        end else if (ready_done) begin
            msb_y_seen_ff <= FLAG_CLEAR;
        end else if (drdy_ff) begin
            msb_y_seen_ff <= nxt_msb_seen[AXIS_Y];
        end
    end

    // Z axis MSB seen while data is ready
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            msb_z_seen_ff <= FLAG_CLEAR;
        end else if (soft_reset) begin
            msb_z_seen_ff <= FLAG_CLEAR;
        end else if (ready_arm) begin
            msb_z_seen_ff <= msb_read[AXIS_Z];
        end else if (ready_done) begin
            msb_z_seen_ff <= FLAG_CLEAR;
        end else if (drdy_ff) begin
            msb_z_seen_ff <= nxt_msb_seen[AXIS_Z];
        end
    end

    // Mode history for change detection
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_ff <= RSECR_MODE_STANDBY;
        end else begin
            mode_ff <= mode;
        end
    end

    // Rate history for change detection
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rate_ff <= RATE_RESET;
        end else begin
            rate_ff <= output_sample_rate;
        end
    end

    // Mode and rate change decode
    assign mode_changed = (mode_ff != mode);
    assign rate_changed = (rate_ff != output_sample_rate);
    assign from_standby = (mode_ff == RSECR_MODE_STANDBY) && (mode == RSECR_MODE_ACTIVE);
    assign from_ready   = (mode_ff == RSECR_MODE_READY) && (mode == RSECR_MODE_ACTIVE);

    // Filter reinit and threshold reset strobes
    assign highpass_reinit = mode_changed || rate_changed || zero_rate_assert;
    assign threshold_reset = from_standby || from_ready;

    // Event combining
    assign fifo_event          = ev.fifo_overflow_flag | ev.fifo_watermark_flag;
    assign enabled_axis_events = ev.axis_event & axis_enable_ff;
    assign event_active_flag   = |enabled_axis_events;

    // Summary sources qualified by their enables
    assign fifo_summary      = gated(fifo_event, fifo_interrupt_enable);
    assign threshold_summary = gated(event_active_flag, threshold_interrupt_enable);

    // Summary byte; flags pass through untouched by reads
    always_comb begin
        summary_byte                 = RSECR_ZERO_BYTE;
        summary_byte[RSECR_SUM_BOOT] = boot_ff;
        summary_byte[RSECR_SUM_FIFO] = fifo_summary;
        summary_byte[RSECR_SUM_RT]   = threshold_summary;
        summary_byte[RSECR_SUM_DRDY] = drdy_ff;
    end

    // Control byte rebuilt from its fields
    always_comb begin
        control_fields                        = CTRL_DEFAULT;
        control_fields.lowpass_cutoff_select  = lowpass_ff;
        control_fields.three_wire_select      = three_wire_ff;
        control_fields.highpass_cutoff_select = highpass_cutoff_ff;
        control_fields.highpass_enable        = highpass_enable_ff;
        control_fields.full_scale_select      = full_scale_ff;
    end
    assign control_byte = control_fields;

    // Threshold config read back with zero padding
    assign rtcfg_byte = {CFG_PAD, latch_enable_ff, axis_enable_ff};

    // Control and config field outputs
    assign ctrl               = control_fields;
    assign full_scale_code    = {range_doubling, full_scale_ff};
    assign event_latch_enable = latch_enable_ff;
    assign axis_event_enable  = axis_enable_ff;

    // Read mux; no read changes any flag
    always_comb begin
        rdata = RSECR_ZERO_BYTE;
        if (acc.rd) begin
            case (acc.addr)
                RSECR_ADDR_SUMMARY: begin
                    rdata = summary_byte;
                end
                RSECR_ADDR_IDENTITY: begin
                    rdata = IDENTITY_CODE;
                end
                RSECR_ADDR_CONTROL: begin
                    rdata = control_byte;
                end
                RSECR_ADDR_RTCFG: begin
                    rdata = rtcfg_byte;
                end
                default: begin
                    rdata = RSECR_ZERO_BYTE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// *** rtl/rsecr_pkg.sv ***
// Package of offsets, field positions and types for the rate sensor register slice
`default_nettype none
package rsecr_pkg;
    localparam logic [7:0] RSECR_ADDR_SUMMARY  = 8'h0B;
    localparam logic [7:0] RSECR_ADDR_IDENTITY = 8'h0C;
    localparam logic [7:0] RSECR_ADDR_CONTROL  = 8'h0D;
    localparam logic [7:0] RSECR_ADDR_RTCFG    = 8'h0E;
    localparam logic [7:0] RSECR_RESET_CONTROL = 8'h00;
    localparam logic [3:0] RSECR_RESET_RTCFG   = 4'h0;
    localparam logic [7:0] RSECR_ZERO_BYTE     = 8'h00;
    // Field positions
    localparam int RSECR_SUM_BOOT = 3;
    localparam int RSECR_SUM_FIFO = 2;
    localparam int RSECR_SUM_RT   = 1;
    localparam int RSECR_SUM_DRDY = 0;
    localparam int RSECR_CFG_ELE  = 3;
    localparam int RSECR_CFG_WIDTH = 4;

    // Operating modes of the sensor
    typedef enum logic [1:0] {
        RSECR_MODE_STANDBY,
        RSECR_MODE_READY,
        RSECR_MODE_ACTIVE
    } rsecr_mode_t;

    // Decoded main control fields
    typedef struct packed {
        logic [1:0] lowpass_cutoff_select;
        logic       three_wire_select;
        logic [1:0] highpass_cutoff_select;
        logic       highpass_enable;
        logic [1:0] full_scale_select;
    } rsecr_ctrl_t;

    // Event inputs from neighbouring blocks
    typedef struct packed {
        logic       fifo_overflow_flag;
        logic       fifo_watermark_flag;
        logic [2:0] axis_event;
        logic       sample_ready_any;
    } rsecr_events_t;

    // Register access strobe group
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rsecr_access_t;
endpackage
`default_nettype wire

// *** tb/rsecr_host.sv ***
// Host model making register accesses over the access strobe group
`default_nettype none
module rsecr_host
    import rsecr_pkg::*;
(
    input  wire logic       clk,
    output rsecr_access_t   acc,
    input  wire logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial acc = '0;
    // One access held to the next edge; the task does not look at the sensor mode
    task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        @(posedge clk) #1 acc = '{rd: !w, wr: w, addr: a, wdata: d};
        @(posedge clk) q = rdata;
        #1 acc = '0;
    endtask
endmodule
`default_nettype wire

// *** tb/rsecr_regs_assertions.sv ***
// Port checker for the register slice
`default_nettype none
module rsecr_regs_assertions
    import rsecr_pkg::*;
#(parameter logic [7:0] IDENTITY_CODE = 8'h5A) (
    input wire logic          clk,
    input wire logic          rst,
    input wire rsecr_access_t acc,
    input wire logic [7:0]    rdata,
    input wire rsecr_events_t ev,
    input wire logic          fifo_interrupt_enable,
    input wire logic          threshold_interrupt_enable,
    input wire rsecr_mode_t   mode,
    input wire logic [2:0]    output_sample_rate,
    input wire logic          zero_rate_assert,
    input wire logic          range_doubling,
    input wire rsecr_ctrl_t   ctrl,
    input wire logic [2:0]    full_scale_code,
    input wire logic          event_latch_enable,
    input wire logic [2:0]    axis_event_enable,
    input wire logic          highpass_reinit,
    input wire logic          threshold_reset
);
    wire logic sum_rd = acc.rd && acc.addr == RSECR_ADDR_SUMMARY;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Read values, write effects and the mode/rate strobes
    property p_idn; acc.rd && acc.addr == RSECR_ADDR_IDENTITY |-> rdata == IDENTITY_CODE; endproperty
    property p_top; sum_rd |-> rdata[7:4] == 4'h0; endproperty
    property p_ff; sum_rd |-> rdata[2] == ((ev.fifo_overflow_flag | ev.fifo_watermark_flag)
        & fifo_interrupt_enable); endproperty
    property p_rt; sum_rd |-> rdata[1] == (|(ev.axis_event & axis_event_enable)
        & threshold_interrupt_enable); endproperty
    property p_wr; acc.wr && acc.addr == RSECR_ADDR_CONTROL |=> ctrl == $past(acc.wdata); endproperty
    property p_cfg; acc.wr && acc.addr == RSECR_ADDR_RTCFG
        |=> axis_event_enable == $past(acc.wdata[2:0]); endproperty
    property p_fs; $changed(ctrl) |-> full_scale_code == {range_doubling, ctrl[1:0]}; endproperty
    property p_hp; mode != $past(mode) |-> highpass_reinit; endproperty
    property p_thr; mode == RSECR_MODE_ACTIVE && $past(mode) != RSECR_MODE_ACTIVE
        |-> threshold_reset; endproperty
    property p_hr; $changed(output_sample_rate) || zero_rate_assert |-> highpass_reinit; endproperty
    property p_ele; acc.wr && acc.addr == RSECR_ADDR_RTCFG
        |=> event_latch_enable == $past(acc.wdata[RSECR_CFG_ELE]); endproperty
    a_idn: assert property (p_idn) else $error("identity read wrong");
    a_top: assert property (p_top) else $error("summary upper bits set");
    a_ff: assert property (p_ff) else $error("fifo summary bit wrong");
    a_rt: assert property (p_rt) else $error("threshold summary bit wrong");
    a_wr: assert property (p_wr) else $error("control write lost");
    a_cfg: assert property (p_cfg) else $error("axis enables wrong");
    a_fs: assert property (p_fs) else $error("full scale code wrong");
    a_hp: assert property (p_hp) else $error("no filter reinit");
    a_thr: assert property (p_thr) else $error("no threshold reset");
    a_hr: assert property (p_hr) else $error("no filter reinit on rate");
    a_ele: assert property (p_ele) else $error("latch enable wrong");
    c_drdy: cover property (sum_rd && rdata[0]);
    c_thr: cover property (threshold_reset);
    c_rt: cover property (sum_rd && rdata[1]);
endmodule
bind rsecr_regs rsecr_regs_assertions #(.IDENTITY_CODE(IDENTITY_CODE)) i_chk (
    .clk(clk), .rst(rst), .acc(acc), .rdata(rdata), .ev(ev),
    .fifo_interrupt_enable(fifo_interrupt_enable),
    .threshold_interrupt_enable(threshold_interrupt_enable), .mode(mode),
    .output_sample_rate(output_sample_rate), .zero_rate_assert(zero_rate_assert),
    .range_doubling(range_doubling), .ctrl(ctrl), .full_scale_code(full_scale_code),
    .event_latch_enable(event_latch_enable), .axis_event_enable(axis_event_enable),
    .highpass_reinit(highpass_reinit), .threshold_reset(threshold_reset));
`default_nettype wire

// *** tb/rate_sensor_event_config_regs_tb.sv ***
// Self-checking bench for the rate sensor register slice
`default_nettype none
module rate_sensor_event_config_regs_tb;
    import rsecr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, sr = 0, boot = 0, fe = 0, te = 0, de = 0, zr = 0, rd2 = 0;
    logic [2:0] msb = 0, osr = 0;
    logic [3:0] cfg = 0;
    logic [7:0] rdata, q, v;
    rsecr_events_t ev = '0;
    rsecr_mode_t mode = RSECR_MODE_STANDBY;
    rsecr_access_t acc;
    int failures = 0, comparisons = 0;
    always #2.5 clk = ~clk;
    rsecr_regs i_dut (.clk(clk), .rst(rst), .soft_reset(sr), .acc(acc), .rdata(rdata),
        .boot_done(boot), .ev(ev), .fifo_interrupt_enable(fe), .threshold_interrupt_enable(te),
        .data_ready_interrupt_enable(de), .msb_read(msb), .mode(mode), .output_sample_rate(osr),
        .zero_rate_assert(zr), .range_doubling(rd2), .ctrl(), .full_scale_code(),
        .event_latch_enable(), .axis_event_enable(), .highpass_reinit(), .threshold_reset());
    rsecr_host i_host (.clk(clk), .acc(acc), .rdata(rdata));
    task automatic check(input logic [7:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // Expected summary byte from bench state
    function automatic logic [7:0] exp_sum(logic bt, logic dr);
        return {4'h0, bt, (ev.fifo_overflow_flag | ev.fifo_watermark_flag) & fe,
            |(ev.axis_event & cfg[2:0]) & te, dr};
    endfunction
    task automatic rdc(input logic [7:0] a, e);
        i_host.xfer(0, a, 8'h00, q);
        check(q, e);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Reset, identity, random register traffic, data-ready and soft reset
    initial begin
        v = $urandom(29);
        repeat (20) @(posedge clk);
        #1 rst = 0;
        rdc(8'h0B, 8'h00);
        i_host.xfer(1, 8'h0C, 8'hFF, q);
        rdc(8'h0C, 8'h5A);
        boot = 1;
        for (int i = 0; i < 24; i++) begin
            mode = RSECR_MODE_STANDBY;
            v = $urandom;
            i_host.xfer(1, 8'h0D, v, q);
            rdc(8'h0D, v);
            i_host.xfer(1, 8'h0E, ~v, q);
            cfg = ~v[3:0];
            rdc(8'h0E, {4'h0, cfg});
            i_host.xfer(1, 8'h0B, v, q);
            {ev, fe, te, rd2} = 9'($urandom);
            mode = rsecr_mode_t'(i % 3);
            osr = 3'(i / 4);
            zr = v[7];
            rdc(8'h0B, exp_sum(1, 0));
            rdc(8'hF0, 8'h00);
        end
        ev = '0;
        de = 1;
        ev.sample_ready_any = 1;
        @(posedge clk) #1 ev.sample_ready_any = 0;
        for (int a = 0; a < 3; a++) begin
            rdc(8'h0B, exp_sum(1, 1));
            msb[a] = 1;
            @(posedge clk) #1 msb = 0;
        end
        rdc(8'h0B, exp_sum(1, 0));
        boot = 0;
        sr = 1;
        @(posedge clk) #1 sr = 0;
        rdc(8'h0B, 8'h00);
        rdc(8'h0D, 8'h00);
        rdc(8'h0E, 8'h00);
        boot = 1;
        rdc(8'h0B, exp_sum(1, 0));
        boot = 0;
        rst = 1;
        @(posedge clk) #1 rst = 0;
        rdc(8'h0B, exp_sum(0, 0));
        end_of_test();
    end
endmodule
`default_nettype wire
